// ===== src/serial_port.sv
// full duplex serial port with multidrop filter and register port
`include "serial_port_defines.svh"

module serial_port (
    input  wire logic       CLOCK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       BAUD_TIMER_RUN,
    input  wire logic       BAUD_TIMER_TICK,
    input  wire logic       BAUD_TIMER_OVF,
    input  wire logic [7:0] BAUD_TIMER_RELOAD_VALUE,
    input  wire logic       RX,
    output logic            TX,
    output logic            IRQ
);
    import serial_port_pkg::*;

    // ------------------------------------------------------------
    // flag update helper
    // ------------------------------------------------------------
    function automatic logic flag_next(input logic set, input logic wr, input logic wbit, input logic cur);
        flag_next = set ? 1'b1 : (wr ? wbit : cur);
    endfunction : flag_next

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic         frame_format_select_r;
    logic         multidrop_filter_enable_r;
    logic         rx_enable_r;
    logic         tx_ninth_bit_r;
    logic         rx_ninth_bit_r;
    logic         tx_done_flag_r;
    logic         rx_done_flag_r;
    logic [7:0]   rdata_r;
    logic         irq_r;

    logic [7:0]   tx_hold_r;
    logic         tx_hold_valid_r;
    logic [8:0]   tx_shift_r;
    logic [3:0]   tx_count_r;
    logic         tx_div_r;
    logic         tx_line_r;
    tx_state_type tx_state_r;

    logic         rx_meta_r;
    logic         rx_sync_r;
    logic         rx_prev_r;
    logic [7:0]   rx_cnt_r;
    logic         rx_phase_r;
    logic [7:0]   rx_shift_r;
    logic         rx_bit9_r;
    logic [3:0]   rx_count_r;
    logic [7:0]   rx_buf_r;
    logic         rx_full_r;
    rx_state_type rx_state_r;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire       sel_ctl  = (ADDR == `ADDR_SERIAL_CONTROL);
    wire       sel_buf  = (ADDR == `ADDR_SERIAL_BUFFER);
    wire       wr_ctl   = WR & sel_ctl;
    wire       wr_buf   = WR & sel_buf;                              // RL1
    wire       rd_buf   = RD & sel_buf;                              // RL1
    wire [7:0] ctl_view = {frame_format_select_r, `CTL_RESERVED_VALUE, multidrop_filter_enable_r,
                           rx_enable_r, tx_ninth_bit_r, rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};
    wire [7:0] rd_mux   = sel_ctl ? ctl_view : (sel_buf ? rx_buf_r : `BYTE_ZERO);  // RL1

    // ------------------------------------------------------------
    // transmit bit clock
    // ------------------------------------------------------------
    wire tx_tick     = BAUD_TIMER_OVF & tx_div_r;                    // RL3 RL16
    wire tx_last     = (tx_count_r == `DATA_BITS - 4'h1);
    wire tx_to_stop  = (tx_state_r == TX_DATA && tx_last && !frame_format_select_r)
                     | (tx_state_r == TX_NINTH);
    wire tx_done_set = tx_tick & tx_to_stop;                         // RL9

    // ------------------------------------------------------------
    // receive bit clock and sampling
    // ------------------------------------------------------------
    wire rx_cnt_step = BAUD_TIMER_RUN & BAUD_TIMER_TICK;             // RL4
    wire rx_ovf      = rx_cnt_step & (rx_cnt_r == `COUNT_TOP);
    wire rx_sample   = rx_ovf & ~rx_phase_r;                         // RL21
    wire rx_fall     = rx_prev_r & ~rx_sync_r;
    wire rx_begin    = (rx_state_r == RX_IDLE) & rx_enable_r & rx_fall;  // RL10
    wire rx_end      = (rx_state_r == RX_STOP) & rx_sample;
    wire rx_ninth    = frame_format_select_r ? rx_bit9_r : rx_sync_r;    // RL14
    wire rx_accept   = ~rx_full_r & (~multidrop_filter_enable_r | rx_ninth);  // RL11
    wire rx_push     = rx_end & rx_accept & rx_enable_r;             // RL12
    wire rx_last     = (rx_count_r == `DATA_BITS - 4'h1);

    // ------------------------------------------------------------
    // control register and read data
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            frame_format_select_r     <= 1'b0;
            multidrop_filter_enable_r <= 1'b0;
            rx_enable_r               <= 1'b0;
            tx_ninth_bit_r            <= 1'b0;
            rx_ninth_bit_r            <= 1'b0;
            tx_done_flag_r            <= 1'b0;
            rx_done_flag_r            <= 1'b0;
            rdata_r                   <= `BYTE_ZERO;
            irq_r                     <= 1'b0;
        end else begin
            if (wr_ctl) begin
                frame_format_select_r     <= WDATA[`CTL_FRAME_FORMAT];  // RL20
                multidrop_filter_enable_r <= WDATA[`CTL_MULTIDROP];
                rx_enable_r               <= WDATA[`CTL_RX_ENABLE];
                tx_ninth_bit_r            <= WDATA[`CTL_TX_NINTH];
            end
            rx_ninth_bit_r <= flag_next(rx_push, wr_ctl, WDATA[`CTL_RX_NINTH], rx_ninth_bit_r) &
                              (rx_push ? rx_ninth : 1'b1);           // RL14
            tx_done_flag_r <= flag_next(tx_done_set, wr_ctl, WDATA[`CTL_TX_DONE], tx_done_flag_r);  // RL9
            rx_done_flag_r <= flag_next(rx_push, wr_ctl, WDATA[`CTL_RX_DONE], rx_done_flag_r);      // RL13
            irq_r          <= tx_done_flag_r | rx_done_flag_r;      // RL2
            if (RD) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit holding stage
    // ------------------------------------------------------------
    wire tx_load = (tx_state_r == TX_IDLE) & tx_hold_valid_r & tx_tick;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_hold_r       <= `BYTE_ZERO;
            tx_hold_valid_r <= 1'b0;
        end else begin
            if (wr_buf) begin
                tx_hold_r       <= WDATA;                            // RL8
                tx_hold_valid_r <= 1'b1;                             // RL15
            end else if (tx_load) begin
                tx_hold_valid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_div_r   <= 1'b0;
            tx_shift_r <= 9'h000;
            tx_count_r <= `BIT_ZERO;
            tx_line_r  <= 1'b1;
            tx_state_r <= TX_IDLE;
        end else begin
            if (BAUD_TIMER_OVF) begin
                tx_div_r <= ~tx_div_r;                               // RL3
            end
            if (tx_tick) begin
                case (tx_state_r)
                    TX_IDLE: begin
                        if (tx_hold_valid_r) begin
                            tx_shift_r <= {tx_ninth_bit_r, tx_hold_r};  // RL8
                            tx_line_r  <= 1'b0;                      // RL6
                            tx_state_r <= TX_START;
                        end
                    end
                    TX_START: begin
                        tx_line_r  <= tx_shift_r[0];                 // RL6
                        tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                        tx_count_r <= `BIT_ZERO;
                        tx_state_r <= TX_DATA;
                    end
                    TX_DATA: begin
                        if (tx_last) begin
                            if (frame_format_select_r) begin
                                tx_line_r  <= tx_shift_r[0];         // RL7
                                tx_state_r <= TX_NINTH;
                            end else begin
                                tx_line_r  <= 1'b1;
                                tx_state_r <= TX_STOP;
                            end
                        end else begin
                            tx_line_r  <= tx_shift_r[0];
                            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                            tx_count_r <= tx_count_r + 4'h1;
                        end
                    end
                    TX_NINTH: begin
                        tx_line_r  <= 1'b1;                          // RL6
                        tx_state_r <= TX_STOP;
                    end
                    TX_STOP: begin
                        tx_state_r <= TX_IDLE;
                    end
                    default: begin
                        tx_line_r  <= 1'b1;
                        tx_state_r <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // receive line synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= RX;                                         // RL21
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    // ------------------------------------------------------------
    // hidden receive counter
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_cnt_r   <= `BYTE_ZERO;
            rx_phase_r <= 1'b0;
        end else begin
            if (rx_begin) begin
                rx_cnt_r   <= BAUD_TIMER_RELOAD_VALUE;               // RL4
                rx_phase_r <= 1'b0;
            end else if (rx_ovf) begin
                rx_cnt_r   <= BAUD_TIMER_RELOAD_VALUE;               // RL4
                rx_phase_r <= ~rx_phase_r;                           // RL3
            end else if (rx_cnt_step) begin
                rx_cnt_r <= rx_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // receive shifter
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_shift_r <= `BYTE_ZERO;
            rx_bit9_r  <= 1'b0;
            rx_count_r <= `BIT_ZERO;
            rx_state_r <= RX_IDLE;
        end else if (!rx_enable_r) begin
            rx_state_r <= RX_IDLE;                                   // RL10
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    if (rx_fall) begin
                        rx_state_r <= RX_START;                      // RL10
                    end
                end
                RX_START: begin
                    if (rx_sample) begin
                        rx_count_r <= `BIT_ZERO;
                        rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;  // RL21
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};  // RL6
                        rx_count_r <= rx_count_r + 4'h1;
                        if (rx_last) begin
                            rx_state_r <= frame_format_select_r ? RX_NINTH : RX_STOP;  // RL7
                        end
                    end
                end
                RX_NINTH: begin
                    if (rx_sample) begin
                        rx_bit9_r  <= rx_sync_r;                     // RL7
                        rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_r <= RX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive holding stage
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_buf_r  <= `BYTE_ZERO;
            rx_full_r <= 1'b0;
        end else begin
            if (rx_push) begin
                rx_buf_r  <= rx_shift_r;                             // RL14
                rx_full_r <= 1'b1;                                   // RL15
            end else if (rd_buf) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA = rdata_r;
    assign TX    = tx_line_r;                                        // RL19
    assign IRQ   = irq_r;                                            // RL2

endmodule : serial_port

// ===== src/serial_port_defines.svh
// register offsets, field positions and reset values of the serial port
//
// Summary of operation
// [RL1] buffer write loads transmit side; buffer read returns receive side only
// [RL2] interrupt asserted while either done flag is set; software clears flags
// [RL3] transmit and receive bit clocks are timer overflows divided by two
// [RL4] hidden receive counter shares reload, is forced to reload on start
// [RL5] software sets timer to overflow at twice the wanted baud rate
// [RL6] frame is low start bit, data lsb first, high stop bit
// [RL7] data field is eight bits, optional ninth bit after the msb
// [RL8] buffer write starts a frame; ninth bit taken from tx ninth bit
// [RL9] transmit done flag set at the start of the stop bit
// [RL10] reception only while receive enabled, starting on a start condition
// [RL11] byte stored only with room and filter off or ninth/stop bit high
// [RL12] byte arriving with the buffer full is dropped, old byte kept
// [RL13] receive done flag set on every byte stored in the buffer
// [RL14] buffer read gives low eight bits; rx ninth bit holds ninth/stop
// [RL15] one holding stage per direction so shifting overlaps software access
// [RL16] transmit up to half clock rate, receive up to one eighth
// [RL17] multidrop master sends address with ninth bit one, data with zero
// [RL18] slave clears filter after address match, sets it after message
// [RL19] transmit and receive paths run at the same time independently
// [RL20] word length bit zero selects eight bits, one selects nine bits
// [RL21] receive line synchronised, start confirmed, bits sampled mid period
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

`define ADDR_SERIAL_CONTROL  8'h00
`define ADDR_SERIAL_BUFFER   8'h01

`define CTL_FRAME_FORMAT     7
`define CTL_RESERVED         6
`define CTL_MULTIDROP        5
`define CTL_RX_ENABLE        4
`define CTL_TX_NINTH         3
`define CTL_RX_NINTH         2
`define CTL_TX_DONE          1
`define CTL_RX_DONE          0

`define CTL_RESERVED_VALUE   1'b1
`define BYTE_ZERO            8'h00
`define COUNT_TOP            8'hFF
`define DATA_BITS            4'h8
`define BIT_ZERO             4'h0

`endif

// ===== src/serial_port_pkg.sv
// types shared by the serial port
package serial_port_pkg;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_NINTH,
        TX_STOP
    } tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_NINTH,
        RX_STOP
    } rx_state_type;

endpackage : serial_port_pkg

// ===== test/far_serial_device.sv
// far serial device: sends frames and decodes what it hears
module far_serial_device #(
    parameter int BIT_CYCLES = 32
) (
    input  wire logic       clock,
    input  wire logic       line_in,
    input  wire logic       nine_mode,
    output logic            line_out,
    output logic      [8:0] got_word,
    output logic            got_stop,
    output int              got_count
);
    initial begin
        line_out = 1'b1;
        got_word = 9'h000;
        got_stop = 1'b0;
        got_count = 0;
    end
    // ----
    // frame out: start low, lsb first, optional ninth, stop high
    // ----
    task automatic send_frame(input logic [7:0] d, input logic n9, input logic use9);
        logic [10:0] b;
        b = use9 ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < (use9 ? 11 : 10); i++) begin
            line_out <= b[i];
            repeat (BIT_CYCLES) @(posedge clock);
        end
    endtask : send_frame
    always begin : decode
        logic [8:0] w;
        @(negedge line_in);
        w = 9'h000;
        repeat (BIT_CYCLES / 2) @(posedge clock);
        for (int i = 0; i < (nine_mode ? 9 : 8); i++) begin
            repeat (BIT_CYCLES) @(posedge clock);
            w[i] = line_in;
        end
        repeat (BIT_CYCLES) @(posedge clock);
        got_stop = line_in;
        got_word = w;
        got_count = got_count + 1;
    end
endmodule : far_serial_device

// ===== test/serial_port_assertions.sv
// pin level checks of the serial port
module serial_port_assertions (
    input wire logic       CLOCK,
    input wire logic       RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       BAUD_TIMER_RUN,
    input wire logic       BAUD_TIMER_TICK,
    input wire logic       BAUD_TIMER_OVF,
    input wire logic [7:0] BAUD_TIMER_RELOAD_VALUE,
    input wire logic       RX,
    input wire logic       TX,
    input wire logic       IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    wire ctl_wr = WR && ADDR == 8'h00;
    wire ctl_rd = RD && ADDR == 8'h00;
    // ----
    // checks
    // ----
    AST_RESET_LEVELS: assert property (
        $rose(RESET_N) |-> TX && !IRQ && RDATA == 8'h00) else $error("bad levels after reset");
    AST_UNMAPPED_READ: assert property (
        RD && ADDR > 8'h01 |=> RDATA == 8'h00) else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (
        !RD |=> $stable(RDATA)) else $error("read data moved without read");
    AST_IRQ_MATCHES_FLAGS: assert property (
        ctl_rd |=> IRQ == (RDATA[1] || RDATA[0])) else $error("irq differs from flags");
    AST_IRQ_HELD: assert property (
        IRQ && !ctl_wr && !$past(ctl_wr) |=> IRQ) else $error("irq dropped without clear");
    AST_CTRL_READBACK: assert property (
        ctl_wr ##1 ctl_rd |=> RDATA[6] && {RDATA[7], RDATA[5:3]} == {$past(WDATA[7], 2), $past(WDATA[5:3], 2)})
        else $error("control readback wrong");
    AST_TX_EDGE_ON_OVF: assert property (
        $changed(TX) |-> $past(BAUD_TIMER_OVF) || $past(BAUD_TIMER_OVF, 2) || $past(BAUD_TIMER_OVF, 3))
        else $error("tx moved off a bit tick");
    AST_START_BIT_LOW: assert property (
        $fell(TX) |-> !TX [*8]) else $error("start bit too short");
    cover property ($fell(TX));
    cover property ($rose(IRQ));
    cover property (RD && ADDR == 8'h01);
endmodule : serial_port_assertions

// ===== test/testbench.sv
// testbench of the serial port with timer model and far device
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin $display("[ERR] %s exp %h got %h", n, e, g); fails++; end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_port_pkg::*;
    logic       CLOCK = 0, RESET_N = 0, WR = 0, RD = 0, ovf_r = 0, nine_mode = 0, run = 1;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, tl_r = 8'h00, v;
    wire  [7:0] RDATA;
    wire        TX, IRQ, RX, got_stop;
    wire  [8:0] got_word;
    int         got_count, fails = 0, cmp_count = 0, cycles = 0;
    serial_port serial_port_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .BAUD_TIMER_RUN(run), .BAUD_TIMER_TICK(1'b1), .BAUD_TIMER_OVF(ovf_r),
        .BAUD_TIMER_RELOAD_VALUE(8'hF0), .RX(RX), .TX(TX), .IRQ(IRQ));
    far_serial_device far_serial_device_i (.clock(CLOCK), .line_in(TX), .nine_mode(nine_mode), .line_out(RX),
        .got_word(got_word), .got_stop(got_stop), .got_count(got_count));
    initial forever #10 CLOCK = ~CLOCK;
    // ----
    // auto reload timer: overflow every 16 cycles, bit is 32
    // ----
    always @(posedge CLOCK) begin
        ovf_r <= run && tl_r == 8'hFF;
        if (run) begin
            tl_r <= tl_r == 8'hFF ? 8'hF0 : tl_r + 8'h01;
        end
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 v = RDATA;
        @(posedge CLOCK);
    endtask : rd
    task automatic sf(input logic [7:0] d, input logic n9, input logic use9);
        far_serial_device_i.send_frame(d, n9, use9);
    endtask : sf
    task automatic wait_frame(input int c);
        for (int k = 0; k < 3000 && got_count <= c; k++) @(posedge CLOCK);
        `CHK("frame seen", 1'b1, got_count > c)
    endtask : wait_frame
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic t_reset();
        rd(8'h00);
        `CHK("ctrl", 8'h40, v)
        wr(8'h07, 8'hFF);
        rd(8'h07);
        `CHK("unmapped", 8'h00, v)
        rd(8'h00);
        `CHK("ctrl kept", 8'h40, v)
        `CHK("irq", 1'b0, IRQ)
        $display("test reset done");
    endtask : t_reset
    task automatic t_tx();
        int c;
        c = got_count;
        wr(8'h01, 8'hA5);
        wait_frame(c);
        `CHK("tx8", 9'h0A5, got_word)
        `CHK("tx8 stop", 1'b1, got_stop)
        rd(8'h00);
        rd(8'h00);
        `CHK("tx done", 1'b1, v[1])
        `CHK("tx irq", 1'b1, IRQ)
        wr(8'h00, 8'h00);
        rd(8'h00);
        `CHK("irq clear", 1'b0, IRQ)
        nine_mode = 1'b1;
        wr(8'h00, 8'h88);
        c = got_count;
        wr(8'h01, 8'h3C);
        repeat (40) @(posedge CLOCK);
        wr(8'h01, 8'hC3);
        wait_frame(c);
        `CHK("tx9 a", 9'h13C, got_word)
        wait_frame(c + 1);
        `CHK("tx9 b", 9'h1C3, got_word)
        nine_mode = 1'b0;
        wr(8'h00, 8'h10);
        $display("test tx done");
    endtask : t_tx
    task automatic t_rx();
        sf(8'h5A, 1'b0, 1'b0);
        rd(8'h00);
        `CHK("rx flags", 3'b101, v[2:0])
        `CHK("rx irq", 1'b1, IRQ)
        rd(8'h01);
        `CHK("rx byte", 8'h5A, v)
        sf(8'h11, 1'b0, 1'b0);
        fork
            sf(8'h22, 1'b0, 1'b0);
            begin
                repeat (150) @(posedge CLOCK);
                rd(8'h01);
            end
        join
        `CHK("held byte", 8'h11, v)
        rd(8'h01);
        `CHK("overlapped byte", 8'h22, v)
        sf(8'h33, 1'b0, 1'b0);
        sf(8'h44, 1'b0, 1'b0);
        rd(8'h01);
        `CHK("old kept", 8'h33, v)
        wr(8'h00, 8'h00);
        sf(8'h66, 1'b0, 1'b0);
        rd(8'h00);
        `CHK("rx off", 1'b0, v[0])
        $display("test rx done");
    endtask : t_rx
    task automatic t_md();
        wr(8'h00, 8'hB0);
        sf(8'h42, 1'b0, 1'b1);
        rd(8'h00);
        `CHK("data filtered", 1'b0, v[0])
        sf(8'h17, 1'b1, 1'b1);
        rd(8'h00);
        `CHK("addr flags", 2'b11, {v[2], v[0]})
        rd(8'h01);
        `CHK("addr byte", 8'h17, v)
        wr(8'h00, 8'h90);
        sf(8'h99, 1'b0, 1'b1);
        rd(8'h00);
        `CHK("data flags", 2'b01, {v[2], v[0]})
        rd(8'h01);
        `CHK("data byte", 8'h99, v)
        wr(8'h00, 8'h10);
        $display("test multidrop done");
    endtask : t_md
    task automatic t_duplex();
        int c;
        c = got_count;
        wr(8'h01, 8'h81);
        sf(8'h7E, 1'b0, 1'b0);
        wait_frame(c);
        `CHK("duplex tx", 9'h081, got_word)
        rd(8'h01);
        `CHK("duplex rx", 8'h7E, v)
        wr(8'h00, 8'h10);
        run <= 1'b0;
        sf(8'h55, 1'b0, 1'b0);
        rd(8'h00);
        `CHK("timer halted", 1'b0, v[0])
        run <= 1'b1;
        $display("test duplex done");
    endtask : t_duplex
    initial begin
        repeat (10) @(posedge CLOCK);
        RESET_N <= 1'b1;
        @(posedge CLOCK);
        t_reset();
        t_tx();
        t_rx();
        t_md();
        t_duplex();
        stop_test();
    end
endmodule : testbench
bind serial_port serial_port_assertions serial_port_assertions_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BAUD_TIMER_RUN(BAUD_TIMER_RUN),
    .BAUD_TIMER_TICK(BAUD_TIMER_TICK), .BAUD_TIMER_OVF(BAUD_TIMER_OVF),
    .BAUD_TIMER_RELOAD_VALUE(BAUD_TIMER_RELOAD_VALUE), .RX(RX), .TX(TX), .IRQ(IRQ));
